// File: rfc_pkg.sv
// field cell library constants: field indices, reset values, cell modes
package rfc_pkg;

   // field width and select width
   localparam int FW = 8;
   localparam int SELW = 5;

   // field indices on the software select
   localparam logic [4:0] F_CONTROL = 5'h00;
   localparam logic [4:0] F_HW_READ = 5'h01;
   localparam logic [4:0] F_READ_ONLY = 5'h02;
   localparam logic [4:0] F_VIRTUAL = 5'h03;
   localparam logic [4:0] F_WRITE_ONLY = 5'h04;
   localparam logic [4:0] F_HW_AFFECTED = 5'h05;
   localparam logic [4:0] F_LH_RDCLR = 5'h06;
   localparam logic [4:0] F_LL_RDCLR = 5'h07;
   localparam logic [4:0] F_LH_MKCLR = 5'h08;
   localparam logic [4:0] F_LL_MKCLR = 5'h09;
   localparam logic [4:0] F_IR_RDCLR = 5'h0A;
   localparam logic [4:0] F_IF_RDCLR = 5'h0B;
   localparam logic [4:0] F_IR_MKCLR = 5'h0C;
   localparam logic [4:0] F_IF_MKCLR = 5'h0D;
   localparam logic [4:0] F_IRQ_ENABLE = 5'h0E;
   localparam logic [4:0] F_RESET_LATCH = 5'h0F;
   localparam logic [4:0] F_SELF_CLEAR = 5'h10;

   // reset values and unmapped read value
   localparam logic [7:0] RST_FIELD = 8'h00;
   localparam logic [7:0] RST_ONES = 8'hFF;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // what an event cell reacts to
   typedef enum logic [1:0] {
      SENSE_HIGH = 2'b00,
      SENSE_LOW = 2'b01,
      SENSE_RISE = 2'b10,
      SENSE_FALL = 2'b11
   } rfc_sense_t;

   // how an event cell is cleared by software
   typedef enum logic {
      CLR_READ = 1'b0,
      CLR_MASK = 1'b1
   } rfc_clear_t;

endpackage : rfc_pkg

// File: rfc_event_cell.sv
`timescale 1ns/100ps
// sticky event field: level or edge sensing, cleared by read or by mask
module rfc_event_cell import rfc_pkg::*; #(
   parameter rfc_sense_t SENSE = SENSE_HIGH,
   parameter rfc_clear_t CLEAR = CLR_READ
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // hardware side
   input wire logic [FW-1:0] hw_in,
   // software side
   input wire logic rd_hit,
   input wire logic wr_hit,
   input wire logic [FW-1:0] wr_mask,
   // field contents
   output logic [FW-1:0] flag
);

   // previous input starts at the level after the sensed edge so reset makes no edge
   localparam logic [FW-1:0] PREV_RST = (SENSE == SENSE_FALL) ? RST_FIELD : RST_ONES;

   logic [FW-1:0] prev;
   logic [FW-1:0] set_bits;
   logic [FW-1:0] clr_bits;

   // input history for edge sensing
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev <= PREV_RST;
      end else begin
         prev <= hw_in;
      end
   end

   // bits to set this cycle
   always_comb begin
      case (SENSE)
         SENSE_HIGH: set_bits = hw_in;
         SENSE_LOW: set_bits = ~hw_in;
         SENSE_RISE: set_bits = hw_in & ~prev;
         SENSE_FALL: set_bits = ~hw_in & prev;
         default: set_bits = RST_FIELD;
      endcase
   end

   // bits software clears this cycle
   always_comb begin
      if (CLEAR == CLR_READ) begin
         clr_bits = rd_hit ? RST_ONES : RST_FIELD;
      end else begin
         clr_bits = wr_hit ? wr_mask : RST_FIELD;
      end
   end

   // sticky flag, a new event beats a clear in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag <= RST_FIELD;
      end else begin
         flag <= (flag & ~clr_bits) | set_bits; // [R18]
      end
   end

endmodule : rfc_event_cell

// File: rfc_field_bank.sv
`timescale 1ns/100ps
// Functional notes
// [R1] rw field holds, reads back, drives hardware
// [R2] hardware read field: one-clock stage, writes ignored
// [R3] read-only field: one-clock capture, not writable
// [R4] virtual read: no storage, input feeds read mux
// [R5] write-only field drives written value to hardware
// [R6] hardware-affected field: hardware load beats software
// [R7] latch high: sticks on high, read clears
// [R8] latch low: sticks on low, read clears
// [R9] latch high: sticks on high, mask-one clears
// [R10] latch low: sticks on low, mask clears
// [R11] rising edge interrupt flag, read clears
// [R12] falling edge interrupt flag, read clears
// [R13] rising edge interrupt flag, mask clears
// [R14] falling edge interrupt flag, mask clears
// [R15] interrupt enable gates its source
// [R16] reset latch field captures input after reset
// [R17] self-clearing field: one-clock strobe, hardware clears
// [R18] set wins over simultaneous clear
module rfc_field_bank import rfc_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // software access
   input wire logic [SELW-1:0] sw_sel,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic [FW-1:0] sw_wdata,
   output logic [FW-1:0] sw_rdata,
   // hardware inputs to stored and pass-through fields
   input wire logic [FW-1:0] hw_read_in,
   input wire logic [FW-1:0] read_only_in,
   input wire logic [FW-1:0] virtual_read_field,
   input wire logic hw_affected_load,
   input wire logic [FW-1:0] hw_affected_data,
   input wire logic [FW-1:0] reset_latch_in,
   input wire logic [FW-1:0] self_clear_done,
   // hardware inputs to event fields
   input wire logic [FW-1:0] latch_high_read_clear,
   input wire logic [FW-1:0] latch_low_read_clear,
   input wire logic [FW-1:0] latch_high_mask_clear,
   input wire logic [FW-1:0] latch_low_mask_clear,
   input wire logic [FW-1:0] irq_rise_read_clear,
   input wire logic [FW-1:0] irq_fall_read_clear,
   input wire logic [FW-1:0] irq_rise_mask_clear,
   input wire logic [FW-1:0] irq_fall_mask_clear,
   // controls to hardware
   output logic [FW-1:0] ctl_control,
   output logic [FW-1:0] ctl_write_only,
   output logic [FW-1:0] ctl_hw_affected,
   output logic [FW-1:0] ctl_reset_latch,
   output logic [FW-1:0] ctl_self_clear,
   output logic [FW-1:0] self_clear_strobe,
   output logic int_req
);

   logic [FW-1:0] hw_read_q;
   logic [FW-1:0] read_only_q;
   logic [FW-1:0] irq_enable;
   logic reset_latch_done;
   logic [FW-1:0] flag_lh_rd;
   logic [FW-1:0] flag_ll_rd;
   logic [FW-1:0] flag_lh_mk;
   logic [FW-1:0] flag_ll_mk;
   logic [FW-1:0] flag_ir_rd;
   logic [FW-1:0] flag_if_rd;
   logic [FW-1:0] flag_ir_mk;
   logic [FW-1:0] flag_if_mk;
   logic [3:0] irq_pending;

   // per-field access decode
   function automatic logic wr_at(input logic [SELW-1:0] idx);
      wr_at = sw_wr && (sw_sel == idx);
   endfunction : wr_at

   function automatic logic rd_at(input logic [SELW-1:0] idx);
      rd_at = sw_rd && (sw_sel == idx);
   endfunction : rd_at

   // plain control field
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_control <= RST_FIELD;
      end else if (wr_at(F_CONTROL)) begin
         ctl_control <= sw_wdata; // [R1]
      end
   end

   // hardware written fields, one register stage, no software path
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hw_read_q <= RST_FIELD;
         read_only_q <= RST_FIELD;
      end else begin
         hw_read_q <= hw_read_in; // [R2]
         read_only_q <= read_only_in; // [R3]
      end
   end

   // write-only control
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_write_only <= RST_FIELD;
      end else if (wr_at(F_WRITE_ONLY)) begin
         ctl_write_only <= sw_wdata; // [R5]
      end
   end

   // hardware-affected field, hardware load wins a collision
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_hw_affected <= RST_FIELD;
      end else if (hw_affected_load) begin
         ctl_hw_affected <= hw_affected_data; // [R6]
      end else if (wr_at(F_HW_AFFECTED)) begin
         ctl_hw_affected <= sw_wdata; // [R6]
      end
   end

   // interrupt enables
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable <= RST_FIELD;
      end else if (wr_at(F_IRQ_ENABLE)) begin
         irq_enable <= sw_wdata; // [R15]
      end
   end

   // reset latch: first clock after release captures input, then plain rw
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_latch_done <= 1'b0;
         ctl_reset_latch <= RST_FIELD;
      end else begin
         reset_latch_done <= 1'b1;
         if (!reset_latch_done) begin
            ctl_reset_latch <= reset_latch_in; // [R16]
         end else if (wr_at(F_RESET_LATCH)) begin
            ctl_reset_latch <= sw_wdata; // [R16]
         end
      end
   end

   // self-clearing field, a write beats the hardware done clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_self_clear <= RST_FIELD;
      end else if (wr_at(F_SELF_CLEAR)) begin
         ctl_self_clear <= sw_wdata; // [R17]
      end else begin
         ctl_self_clear <= ctl_self_clear & ~self_clear_done; // [R17]
      end
   end

   // one-clock strobe carrying the written bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         self_clear_strobe <= RST_FIELD;
      end else begin
         self_clear_strobe <= wr_at(F_SELF_CLEAR) ? sw_wdata : RST_FIELD; // [R17]
      end
   end

   // level latch cells
   rfc_event_cell #(.SENSE(SENSE_HIGH), .CLEAR(CLR_READ)) u_lh_rd ( // [R7]
      .clock(clock), .rst_n(rst_n), .hw_in(latch_high_read_clear),
      .rd_hit(rd_at(F_LH_RDCLR)), .wr_hit(wr_at(F_LH_RDCLR)), .wr_mask(sw_wdata),
      .flag(flag_lh_rd)
   );
   rfc_event_cell #(.SENSE(SENSE_LOW), .CLEAR(CLR_READ)) u_ll_rd ( // [R8]
      .clock(clock), .rst_n(rst_n), .hw_in(latch_low_read_clear),
      .rd_hit(rd_at(F_LL_RDCLR)), .wr_hit(wr_at(F_LL_RDCLR)), .wr_mask(sw_wdata),
      .flag(flag_ll_rd)
   );
   rfc_event_cell #(.SENSE(SENSE_HIGH), .CLEAR(CLR_MASK)) u_lh_mk ( // [R9]
      .clock(clock), .rst_n(rst_n), .hw_in(latch_high_mask_clear),
      .rd_hit(rd_at(F_LH_MKCLR)), .wr_hit(wr_at(F_LH_MKCLR)), .wr_mask(sw_wdata),
      .flag(flag_lh_mk)
   );
   rfc_event_cell #(.SENSE(SENSE_LOW), .CLEAR(CLR_MASK)) u_ll_mk ( // [R10]
      .clock(clock), .rst_n(rst_n), .hw_in(latch_low_mask_clear),
      .rd_hit(rd_at(F_LL_MKCLR)), .wr_hit(wr_at(F_LL_MKCLR)), .wr_mask(sw_wdata),
      .flag(flag_ll_mk)
   );

   // edge interrupt cells
   rfc_event_cell #(.SENSE(SENSE_RISE), .CLEAR(CLR_READ)) u_ir_rd ( // [R11]
      .clock(clock), .rst_n(rst_n), .hw_in(irq_rise_read_clear),
      .rd_hit(rd_at(F_IR_RDCLR)), .wr_hit(wr_at(F_IR_RDCLR)), .wr_mask(sw_wdata),
      .flag(flag_ir_rd)
   );
   rfc_event_cell #(.SENSE(SENSE_FALL), .CLEAR(CLR_READ)) u_if_rd ( // [R12]
      .clock(clock), .rst_n(rst_n), .hw_in(irq_fall_read_clear),
      .rd_hit(rd_at(F_IF_RDCLR)), .wr_hit(wr_at(F_IF_RDCLR)), .wr_mask(sw_wdata),
      .flag(flag_if_rd)
   );
   rfc_event_cell #(.SENSE(SENSE_RISE), .CLEAR(CLR_MASK)) u_ir_mk ( // [R13]
      .clock(clock), .rst_n(rst_n), .hw_in(irq_rise_mask_clear),
      .rd_hit(rd_at(F_IR_MKCLR)), .wr_hit(wr_at(F_IR_MKCLR)), .wr_mask(sw_wdata),
      .flag(flag_ir_mk)
   );
   rfc_event_cell #(.SENSE(SENSE_FALL), .CLEAR(CLR_MASK)) u_if_mk ( // [R14]
      .clock(clock), .rst_n(rst_n), .hw_in(irq_fall_mask_clear),
      .rd_hit(rd_at(F_IF_MKCLR)), .wr_hit(wr_at(F_IF_MKCLR)), .wr_mask(sw_wdata),
      .flag(flag_if_mk)
   );

   // enable bit n gates interrupt field n (0..3), registered request
   assign irq_pending = {|flag_if_mk, |flag_ir_mk, |flag_if_rd, |flag_ir_rd};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         int_req <= 1'b0;
      end else begin
         int_req <= |(irq_pending & irq_enable[3:0]); // [R15]
      end
   end

   // read multiplexer, shows pre-clear value in the read cycle
   always_comb begin
      case (sw_sel)
         F_CONTROL: sw_rdata = ctl_control;
         F_HW_READ: sw_rdata = hw_read_q;
         F_READ_ONLY: sw_rdata = read_only_q;
         F_VIRTUAL: sw_rdata = virtual_read_field; // [R4]
         F_WRITE_ONLY: sw_rdata = RD_UNMAPPED;
         F_HW_AFFECTED: sw_rdata = ctl_hw_affected;
         F_LH_RDCLR: sw_rdata = flag_lh_rd;
         F_LL_RDCLR: sw_rdata = flag_ll_rd;
         F_LH_MKCLR: sw_rdata = flag_lh_mk;
         F_LL_MKCLR: sw_rdata = flag_ll_mk;
         F_IR_RDCLR: sw_rdata = flag_ir_rd;
         F_IF_RDCLR: sw_rdata = flag_if_rd;
         F_IR_MKCLR: sw_rdata = flag_ir_mk;
         F_IF_MKCLR: sw_rdata = flag_if_mk;
         F_IRQ_ENABLE: sw_rdata = irq_enable;
         F_RESET_LATCH: sw_rdata = ctl_reset_latch;
         F_SELF_CLEAR: sw_rdata = ctl_self_clear;
         default: sw_rdata = RD_UNMAPPED;
      endcase
   end

   // checks on field behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_control_write_hold: assert property ( // [R1]
      wr_at(F_CONTROL) ##1 !wr_at(F_CONTROL) |-> ctl_control == $past(sw_wdata)
   ) else $error("control field lost written value");

   a_hw_read_stage: assert property ( // [R2]
      wr_at(F_HW_READ) |=> hw_read_q == $past(hw_read_in)
   ) else $error("hardware read field not one-clock copy");

   a_read_only_stage: assert property ( // [R3]
      sw_sel == F_READ_ONLY ##1 sw_sel == F_READ_ONLY |-> sw_rdata == $past(read_only_in)
   ) else $error("read-only field not one-clock copy");

   a_virtual_pass: assert property ( // [R4]
      sw_sel == F_VIRTUAL |-> sw_rdata == virtual_read_field
   ) else $error("virtual field not passed straight through");

   a_write_only_drive: assert property ( // [R5]
      wr_at(F_WRITE_ONLY) |=> ctl_write_only == $past(sw_wdata)
   ) else $error("write-only field not driven");

   a_hw_affected_win: assert property ( // [R6]
      hw_affected_load && wr_at(F_HW_AFFECTED) |=> ctl_hw_affected == $past(hw_affected_data)
   ) else $error("hardware load lost to software write");

   a_latch_high_set: assert property ( // [R7]
      rd_at(F_LH_RDCLR) |=> (flag_lh_rd & $past(latch_high_read_clear))
                            == $past(latch_high_read_clear)
   ) else $error("latched high event lost on read");

   a_latch_low_clear: assert property ( // [R8]
      rd_at(F_LL_RDCLR) && latch_low_read_clear == RST_ONES |=> flag_ll_rd == RST_FIELD
   ) else $error("latch low field not cleared by read");

   a_latch_mask_clear: assert property ( // [R9]
      wr_at(F_LH_MKCLR) |=> (flag_lh_mk & $past(sw_wdata) & ~$past(latch_high_mask_clear))
                            == RST_FIELD
   ) else $error("mask write did not clear latch high bits");

   a_latch_low_mask: assert property ( // [R10]
      !wr_at(F_LL_MKCLR) |=> (flag_ll_mk & $past(flag_ll_mk)) == $past(flag_ll_mk)
   ) else $error("latch low field dropped without mask");

   a_rise_read_clear: assert property ( // [R11]
      rd_at(F_IR_RDCLR) && irq_rise_read_clear == $past(irq_rise_read_clear)
      |=> flag_ir_rd == RST_FIELD
   ) else $error("rising interrupt flag not cleared by read");

   a_fall_set_hold: assert property ( // [R12]
      !rd_at(F_IF_RDCLR) |=> (flag_if_rd & $past(flag_if_rd)) == $past(flag_if_rd)
   ) else $error("falling interrupt flag dropped without read");

   a_rise_mask_clear: assert property ( // [R13]
      wr_at(F_IR_MKCLR) && irq_rise_mask_clear == $past(irq_rise_mask_clear)
      |=> (flag_ir_mk & $past(sw_wdata)) == RST_FIELD
   ) else $error("rising mask interrupt not cleared");

   a_fall_mask_set: assert property ( // [R14]
      $fell(irq_fall_mask_clear[0]) |=> flag_if_mk[0]
   ) else $error("falling edge not caught");

   a_irq_gate: assert property ( // [R15]
      irq_enable[3:0] == 4'h0 ##1 irq_enable[3:0] == 4'h0 |-> !int_req
   ) else $error("interrupt raised while disabled");

   a_reset_latch_cap: assert property ( // [R16]
      !reset_latch_done |=> ctl_reset_latch == $past(reset_latch_in)
   ) else $error("reset latch did not capture input");

   a_strobe_one_clock: assert property ( // [R17]
      self_clear_strobe != RST_FIELD |-> $past(wr_at(F_SELF_CLEAR))
   ) else $error("strobe without a write");

   // further checks: holds without triggers, set priority, interrupt raise, hardware clear
   a_control_stable: assert property ( // [R1]
      !wr_at(F_CONTROL) |=> $stable(ctl_control)
   ) else $error("control field changed without a write");

   a_low_set_wins: assert property ( // [R18]
      wr_at(F_LL_MKCLR) |=> (flag_ll_mk | $past(latch_low_mask_clear)) == RST_ONES
   ) else $error("latch low event lost to mask write");

   a_irq_raise: assert property ( // [R15]
      (irq_pending & irq_enable[3:0]) != 4'h0 |=> int_req
   ) else $error("enabled interrupt not requested");

   a_reset_latch_hold: assert property ( // [R16]
      reset_latch_done && !wr_at(F_RESET_LATCH) |=> $stable(ctl_reset_latch)
   ) else $error("reset latch field changed without a write");

   a_self_clear_done: assert property ( // [R17]
      !wr_at(F_SELF_CLEAR) |=> (ctl_self_clear & $past(self_clear_done)) == RST_FIELD
   ) else $error("self-clearing bits not cleared by hardware");

   c_control_write: cover property (wr_at(F_CONTROL) ##1 sw_rd && sw_sel == F_CONTROL);
   c_read_clear_set: cover property (rd_at(F_LH_RDCLR) && flag_lh_rd != RST_FIELD);
   c_strobe_pulse: cover property (self_clear_strobe != RST_FIELD);
   c_irq_raise: cover property ($rose(int_req));
   c_set_beats_clear: cover property (
      wr_at(F_LL_MKCLR) && (sw_wdata & ~latch_low_mask_clear) != RST_FIELD
   );

endmodule : rfc_field_bank

// File: rfc_field_bank_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module rfc_field_bank_test import rfc_pkg::*;;
   typedef struct {int k; logic [FW-1:0] e;} rfc_note_t;
   logic clock, rst_n, sw_wr, sw_rd, hw_affected_load, int_req;
   logic [SELW-1:0] sw_sel;
   logic [FW-1:0] sw_wdata, sw_rdata, hw_read_in, read_only_in, virtual_read_field;
   logic [FW-1:0] hw_affected_data, reset_latch_in, self_clear_done;
   logic [FW-1:0] ctl_control, ctl_write_only, ctl_hw_affected, ctl_reset_latch;
   logic [FW-1:0] ctl_self_clear, self_clear_strobe;
   logic [FW-1:0] ev_in [8];
   rfc_note_t notes [$];
   rfc_note_t n;
   int fails, cmp_count;
   string nm [8] = '{"sw_rdata", "ctl_control", "ctl_write_only", "ctl_hw_affected",
      "ctl_reset_latch", "ctl_self_clear", "self_clear_strobe", "int_req"};

   rfc_field_bank i_dut (.clock(clock), .rst_n(rst_n), .sw_sel(sw_sel), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_wdata(sw_wdata), .sw_rdata(sw_rdata), .hw_read_in(hw_read_in),
      .read_only_in(read_only_in), .virtual_read_field(virtual_read_field),
      .hw_affected_load(hw_affected_load), .hw_affected_data(hw_affected_data),
      .reset_latch_in(reset_latch_in), .self_clear_done(self_clear_done),
      .latch_high_read_clear(ev_in[0]), .latch_low_read_clear(ev_in[1]),
      .latch_high_mask_clear(ev_in[2]), .latch_low_mask_clear(ev_in[3]),
      .irq_rise_read_clear(ev_in[4]), .irq_fall_read_clear(ev_in[5]),
      .irq_rise_mask_clear(ev_in[6]), .irq_fall_mask_clear(ev_in[7]),
      .ctl_control(ctl_control), .ctl_write_only(ctl_write_only),
      .ctl_hw_affected(ctl_hw_affected), .ctl_reset_latch(ctl_reset_latch),
      .ctl_self_clear(ctl_self_clear), .self_clear_strobe(self_clear_strobe),
      .int_req(int_req));

   // clock generator
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // picks the output that a note refers to
   function automatic logic [FW-1:0] obs(input int k);
      case (k)
         0: return sw_rdata;
         1: return ctl_control;
         2: return ctl_write_only;
         3: return ctl_hw_affected;
         4: return ctl_reset_latch;
         5: return ctl_self_clear;
         6: return self_clear_strobe;
         default: return {7'h00, int_req};
      endcase
   endfunction : obs

   // monitor: values seen before the edge are those of the cycle just ended
   always @(posedge clock) begin
      while (notes.size() > 0) begin
         n = notes.pop_front();
         `CHK(nm[n.k], n.e, obs(n.k))
      end
   end

   task automatic give_verdict;
      if (fails == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // one software cycle, launched at the falling edge
   task automatic go(input logic w, r, input logic [SELW-1:0] s, input logic [FW-1:0] d);
      @(negedge clock);
      sw_wr = w;
      sw_rd = r;
      sw_sel = s;
      sw_wdata = d;
   endtask : go

   task automatic ex(input int k, input logic [FW-1:0] e);
      notes.push_back(rfc_note_t'{k, e});
   endtask : ex

   task automatic do_reset(input logic [FW-1:0] r0);
      @(negedge clock);
      rst_n = 1'b0;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      reset_latch_in = r0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      go(0, 1, F_CONTROL, 8'h00);
      reset_latch_in = ~r0;
      ex(4, r0);
      ex(1, RST_FIELD);
      ex(0, RST_FIELD);
      go(0, 0, F_CONTROL, 8'h00);
      ex(4, r0);
   endtask : do_reset

   // write then read back a software-owned field
   task automatic rw_field(input logic [SELW-1:0] s, input int k);
      logic [FW-1:0] d;
      d = FW'($urandom);
      go(1, 0, s, d);
      go(0, 1, s, 8'h00);
      ex(0, (s == F_WRITE_ONLY) ? RD_UNMAPPED : d);
      if (k > 0) ex(k, d);
   endtask : rw_field

   // hardware-loaded field: one-clock stage, software writes ignored
   task automatic hw_stage(input logic [SELW-1:0] s);
      logic [FW-1:0] a;
      a = FW'($urandom);
      go(1, 0, s, ~a);
      if (s == F_HW_READ) hw_read_in = a; else read_only_in = a;
      go(0, 1, s, 8'h00);
      if (s == F_HW_READ) hw_read_in = ~a; else read_only_in = ~a;
      ex(0, a);
      go(0, 1, s, 8'h00);
      ex(0, ~a);
   endtask : hw_stage

   // active and idle levels of an event input
   task automatic act(input logic [2:0] i, input logic [FW-1:0] v);
      ev_in[i] = i[0] ? ~v : v;
   endtask : act

   task automatic rest(input logic [2:0] i);
      ev_in[i] = i[0] ? 8'hFF : 8'h00;
   endtask : rest

   // event field: set, hold, clear by read or mask, set beats clear
   task automatic ev(input logic [2:0] i);
      logic [SELW-1:0] s;
      logic [FW-1:0] p, m, q, en;
      logic lvl, mk;
      s = F_LH_RDCLR + SELW'(i);
      lvl = !i[2];
      mk = i[1];
      p = FW'($urandom) | 8'h01;
      q = FW'($urandom) | 8'h01;
      m = FW'($urandom);
      en = FW'($urandom);
      go(1, 0, F_IRQ_ENABLE, en);
      go(1, 0, s, 8'h00);
      act(i, p);
      go(1, 1, s, 8'h00);
      ex(0, p);
      go(1, 1, s, m);
      rest(i);
      ex(0, (mk || lvl) ? p : 8'h00);
      ex(7, {7'h00, !lvl && en[i[1:0]]});
      go(1, 1, s, 8'hFF);
      act(i, q);
      ex(0, mk ? (p & ~m) : 8'h00);
      go(1, 1, s, 8'hFF);
      rest(i);
      ex(0, q);
      go(0, 1, s, 8'h00);
      ex(0, 8'h00);
      go(0, 0, s, 8'h00);
      ex(7, 8'h00);
   endtask : ev

   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      give_verdict();
   end

   // main sequence
   initial begin
      logic [FW-1:0] d1, d2;
      rst_n = 1'b0;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      sw_sel = F_CONTROL;
      sw_wdata = 8'h00;
      hw_read_in = 8'h00;
      read_only_in = 8'h00;
      virtual_read_field = 8'h00;
      hw_affected_load = 1'b0;
      hw_affected_data = 8'h00;
      reset_latch_in = 8'h00;
      self_clear_done = 8'h00;
      for (int i = 0; i < 8; i++) rest(3'(i));
      fails = 0;
      cmp_count = 0;
      void'($urandom(48));
      do_reset(FW'($urandom));
      repeat (3) begin
         rw_field(F_CONTROL, 1);
         rw_field(F_WRITE_ONLY, 2);
         rw_field(F_IRQ_ENABLE, 0);
         rw_field(F_RESET_LATCH, 4);
      end
      go(1, 1, 5'h1F, 8'hFF);
      ex(0, RD_UNMAPPED);
      hw_stage(F_HW_READ);
      hw_stage(F_READ_ONLY);
      d1 = FW'($urandom);
      go(1, 1, F_VIRTUAL, ~d1);
      virtual_read_field = d1;
      ex(0, d1);
      go(0, 1, F_VIRTUAL, 8'h00);
      virtual_read_field = ~d1;
      ex(0, ~d1);
      // hardware-affected field, hardware load wins
      d2 = FW'($urandom);
      go(1, 0, F_HW_AFFECTED, d1);
      hw_affected_load = 1'b1;
      hw_affected_data = d2;
      go(1, 1, F_HW_AFFECTED, ~d2);
      hw_affected_load = 1'b0;
      ex(3, d2);
      ex(0, d2);
      go(0, 0, F_HW_AFFECTED, 8'h00);
      hw_affected_load = 1'b1;
      hw_affected_data = d1;
      ex(3, ~d2);
      go(0, 0, F_HW_AFFECTED, 8'h00);
      hw_affected_load = 1'b0;
      ex(3, d1);
      // self-clearing field
      d1 = FW'($urandom) | 8'h01;
      d2 = FW'($urandom);
      go(1, 0, F_SELF_CLEAR, d1);
      go(0, 1, F_SELF_CLEAR, 8'h00);
      ex(6, d1);
      ex(5, d1);
      ex(0, d1);
      go(0, 0, F_SELF_CLEAR, 8'h00);
      self_clear_done = d2;
      ex(6, 8'h00);
      go(1, 0, F_SELF_CLEAR, ~d1);
      self_clear_done = 8'hFF;
      ex(5, d1 & ~d2);
      go(0, 0, F_SELF_CLEAR, 8'h00);
      self_clear_done = 8'h00;
      ex(5, ~d1);
      ex(6, ~d1);
      // event fields, each kind
      ev(3'd0);
      ev(3'd1);
      ev(3'd2);
      ev(3'd3);
      ev(3'd4);
      ev(3'd5);
      ev(3'd6);
      ev(3'd7);
      do_reset(FW'($urandom));
      go(0, 0, F_CONTROL, 8'h00);
      give_verdict();
   end
endmodule : rfc_field_bank_test
